//--- logic/udier_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes
`timescale 1ns/1ps
module udier_axil_slave
    import udier_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    udier_reg_if.bus               regs
);

    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    logic              do_write;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    assign regs.wr_en   = do_write;
    assign regs.wr_addr = aw_addr;
    assign regs.wr_data = w_data;
    assign regs.wr_strb = w_strb;
    assign regs.rd_addr = s_axi_araddr;

    // Address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= regs.wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= regs.rd_hit ? regs.rd_data : '0;
            s_axi_rresp  <= regs.rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : udier_axil_slave

//--- logic/udier_top.sv
// Interrupt mask, status, clear and endpoint reset registers of the USB device port
`timescale 1ns/1ps
module udier_top
    import udier_pkg::*;
#(
    parameter int unsigned SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_DEFAULT
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [NUM_EP-1:0] setup_received_flag,
    input  wire logic [NUM_EP-1:0] rx_bank_zero_flag,
    input  wire logic [NUM_EP-1:0] rx_bank_one_flag,
    input  wire logic [NUM_EP-1:0] tx_complete_flag,
    input  wire logic [NUM_EP-1:0] stall_acked_flag,
    input  wire logic              bus_activity,
    input  wire logic              resume_seen,
    input  wire logic              frame_start_seen,
    input  wire logic              bus_reset_done,
    input  wire logic              bus_reset_seen,
    output logic                   irq,
    output logic                   suspend_mode,
    output logic [NUM_EP-1:0]      endpoint_fifo_clear
);

    localparam int unsigned IDLE_W = $clog2(SUSPEND_IDLE_CYCLES + 1);
    localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(SUSPEND_IDLE_CYCLES - 1);

    udier_reg_if regs ();

    udier_axil_slave u_slave (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .regs          (regs.bus)
    );

    logic [31:0]       irq_mask;
    logic [31:0]       next_irq_mask;
    logic [31:0]       bus_status;
    logic [31:0]       next_bus_status;
    logic [31:0]       endpoint_reset;
    logic [NUM_EP-1:0] ep_status;
    logic [31:0]       mask_view;
    logic [31:0]       status_view;
    logic [31:0]       bus_events;
    logic [31:0]       wr_lanes;
    logic [31:0]       wr_bits;
    logic              wr_enable;
    logic              wr_disable;
    logic              wr_clear;
    logic              wr_ep_reset;
    udier_link_t       link_state;
    logic [IDLE_W-1:0] idle_count;
    logic              suspend_enter;

    // Write decode; masked byte lanes count as zero bits, except that endpoint reset skips a write with lane 0 masked
    assign wr_lanes = {{8{regs.wr_strb[3]}}, {8{regs.wr_strb[2]}},
                       {8{regs.wr_strb[1]}}, {8{regs.wr_strb[0]}}};
    assign wr_bits     = regs.wr_data & wr_lanes;
    assign wr_enable   = regs.wr_en && (regs.wr_addr == OFF_IRQ_ENABLE);
    assign wr_disable  = regs.wr_en && (regs.wr_addr == OFF_IRQ_DISABLE);
    assign wr_clear    = regs.wr_en && (regs.wr_addr == OFF_IRQ_CLEAR);
    assign wr_ep_reset = regs.wr_en && (regs.wr_addr == OFF_ENDPOINT_RESET);

    always_comb begin
        case (regs.wr_addr)
            OFF_IRQ_ENABLE,
            OFF_IRQ_DISABLE,
            OFF_IRQ_MASK,
            OFF_IRQ_STATUS,
            OFF_IRQ_CLEAR,
            OFF_ENDPOINT_RESET: regs.wr_hit = 1'b1;
            default:            regs.wr_hit = 1'b0;
        endcase
    end

    // Mask set by enable writes, cleared by disable writes
    always_comb begin
        next_irq_mask = irq_mask;
        if (wr_enable) begin
            next_irq_mask = irq_mask | (wr_bits & MASK_WRITABLE);
        end else if (wr_disable) begin
            next_irq_mask = irq_mask & ~(wr_bits & MASK_WRITABLE);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= MASK_RESET & MASK_WRITABLE;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    assign mask_view = irq_mask | MASK_UNMASKABLE;

    // Endpoint status mirrors the sticky endpoint flags
    generate
        for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
            assign ep_status[e] = setup_received_flag[e] | rx_bank_zero_flag[e] |
                                  rx_bank_one_flag[e] | tx_complete_flag[e] |
                                  stall_acked_flag[e];
        end
    endgenerate

    // Suspend detection on bus idle time
    assign suspend_enter = (link_state == UDIER_LINK_ACTIVE) && !bus_activity &&
                           (idle_count == IDLE_LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_state <= UDIER_LINK_ACTIVE;
            idle_count <= '0;
        end else begin
            case (link_state)
                UDIER_LINK_ACTIVE: begin
                    if (bus_activity) begin
                        idle_count <= '0;
                    end else if (suspend_enter) begin
                        idle_count <= '0;
                        link_state <= UDIER_LINK_SUSPENDED;
                    end else begin
                        idle_count <= idle_count + IDLE_W'(1);
                    end
                end
                UDIER_LINK_SUSPENDED: begin
                    idle_count <= '0;
                    if (bus_activity) begin
                        link_state <= UDIER_LINK_ACTIVE;
                    end
                end
                default: begin
                    link_state <= UDIER_LINK_ACTIVE;
                    idle_count <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            suspend_mode <= 1'b0;
        end else begin
            suspend_mode <= suspend_enter ||
                            ((link_state == UDIER_LINK_SUSPENDED) && !bus_activity);
        end
    end

    // Bus event status; a new event wins over a clear in the same cycle
    always_comb begin
        bus_events                     = '0;
        bus_events[BIT_SUSPEND]        = suspend_enter;
        bus_events[BIT_RESUME]         = resume_seen;
        bus_events[BIT_FRAME_START]    = frame_start_seen;
        bus_events[BIT_BUS_RESET_DONE] = bus_reset_done;
        bus_events[BIT_WAKEUP]         = resume_seen | bus_reset_seen;
    end

    always_comb begin
        next_bus_status = bus_status;
        if (wr_clear) begin
            next_bus_status = bus_status & ~(wr_bits & STATUS_BUS_BITS);
        end
        next_bus_status = (next_bus_status | bus_events) & STATUS_BUS_BITS;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_status <= STATUS_RESET;
        end else begin
            bus_status <= next_bus_status;
        end
    end

    assign status_view = bus_status |
                         {{(32 - NUM_EP - BIT_EP_FIRST){1'b0}}, ep_status};

    // Endpoint reset bits drive the endpoint FIFO clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            endpoint_reset <= ENDPOINT_RESET_RESET;
        end else if (wr_ep_reset && regs.wr_strb[0]) begin
            endpoint_reset <= regs.wr_data & ENDPOINT_RESET_BITS;
        end
    end

    assign endpoint_fifo_clear = endpoint_reset[NUM_EP-1:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_view & mask_view);
        end
    end

    // Read decode; write-only registers read as zero
    always_comb begin
        regs.rd_hit  = 1'b1;
        regs.rd_data = '0;
        case (regs.rd_addr)
            OFF_IRQ_ENABLE:     regs.rd_data = '0;
            OFF_IRQ_DISABLE:    regs.rd_data = '0;
            OFF_IRQ_CLEAR:      regs.rd_data = '0;
            OFF_IRQ_MASK:       regs.rd_data = mask_view;
            OFF_IRQ_STATUS:     regs.rd_data = status_view;
            OFF_ENDPOINT_RESET: regs.rd_data = endpoint_reset;
            default:            regs.rd_hit  = 1'b0;
        endcase
    end

endmodule : udier_top

//--- shared/udier_pkg.sv
// Register map, field layout, reset values and timing counts of the interrupt block
package udier_pkg;

    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned NUM_EP  = 6;

    // Byte offsets of the registers
    localparam logic [7:0] OFF_IRQ_ENABLE     = 8'h10;
    localparam logic [7:0] OFF_IRQ_DISABLE    = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK       = 8'h18;
    localparam logic [7:0] OFF_IRQ_STATUS     = 8'h1c;
    localparam logic [7:0] OFF_IRQ_CLEAR      = 8'h20;
    localparam logic [7:0] OFF_ENDPOINT_RESET = 8'h28;

    // Bit positions of the interrupt sources
    localparam int unsigned BIT_EP_FIRST        = 0;
    localparam int unsigned BIT_SUSPEND         = 8;
    localparam int unsigned BIT_RESUME          = 9;
    localparam int unsigned BIT_FRAME_START     = 11;
    localparam int unsigned BIT_BUS_RESET_DONE  = 12;
    localparam int unsigned BIT_WAKEUP          = 13;

    // Field masks and reset values
    localparam logic [31:0] MASK_WRITABLE        = 32'h0000_2b3f;
    localparam logic [31:0] MASK_UNMASKABLE      = 32'h0000_1000;
    localparam logic [31:0] MASK_RESET           = 32'h0000_1200;
    localparam logic [31:0] STATUS_BUS_BITS      = 32'h0000_3b00;
    localparam logic [31:0] STATUS_RESET         = 32'h0000_0000;
    localparam logic [31:0] ENDPOINT_RESET_BITS  = 32'h0000_003f;
    localparam logic [31:0] ENDPOINT_RESET_RESET = 32'h0000_0000;

    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Bus idle time before suspend, and its count of clock cycles
    localparam int unsigned CLK_PERIOD_NS        = 50;
    localparam int unsigned SUSPEND_IDLE_NS      = 3000000;
    localparam int unsigned SUSPEND_IDLE_DEFAULT =
        (SUSPEND_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        UDIER_LINK_ACTIVE    = 1'b0,
        UDIER_LINK_SUSPENDED = 1'b1
    } udier_link_t;

endpackage : udier_pkg

//--- shared/udier_reg_if.sv
// Register access carrier between the bus slave and the register block
`timescale 1ns/1ps
interface udier_reg_if;
    import udier_pkg::*;

    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0]        wr_strb;
    logic              wr_hit;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic              rd_hit;

    modport bus (
        output wr_en,
        output wr_addr,
        output wr_data,
        output wr_strb,
        output rd_addr,
        input  wr_hit,
        input  rd_data,
        input  rd_hit
    );

    modport regs (
        input  wr_en,
        input  wr_addr,
        input  wr_data,
        input  wr_strb,
        input  rd_addr,
        output wr_hit,
        output rd_data,
        output rd_hit
    );
endinterface : udier_reg_if

//--- sim/udier_host_model.sv
// Behavioural host driving bus events into the interrupt block
`timescale 1ns/1ps
module udier_host_model (
    input  wire logic aclk,
    output logic      bus_activity,
    output logic      resume_seen,
    output logic      frame_start_seen,
    output logic      bus_reset_done,
    output logic      bus_reset_seen
);
    initial begin
        bus_activity     = 1'b1;
        resume_seen      = 1'b0;
        frame_start_seen = 1'b0;
        bus_reset_done   = 1'b0;
        bus_reset_seen   = 1'b0;
    end
    task automatic set_active(input logic v);
        bus_activity <= v;
    endtask : set_active
    // Kind 1 frame start, 2 resume, 3 bus reset
    task automatic send(input int k);
        frame_start_seen <= (k == 1);
        resume_seen      <= (k == 2);
        bus_reset_seen   <= (k == 3);
        @(posedge aclk);
        frame_start_seen <= 1'b0;
        resume_seen      <= 1'b0;
        bus_reset_seen   <= 1'b0;
        if (k == 3) begin
            repeat (4) @(posedge aclk);
            bus_reset_done <= 1'b1;
            @(posedge aclk);
            bus_reset_done <= 1'b0;
        end
        @(posedge aclk);
    endtask : send
endmodule : udier_host_model

//--- sim/udier_props.sv
// Port-level checker of the interrupt block
`timescale 1ns/1ps
module udier_props
    import udier_pkg::*;
#(
    parameter int unsigned SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_DEFAULT
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              bus_activity,
    input wire logic              bus_reset_done,
    input wire logic              irq,
    input wire logic              suspend_mode,
    input wire logic [NUM_EP-1:0] endpoint_fifo_clear
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Consecutive idle cycles on the bus
    logic [31:0] idle_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || bus_activity) begin
            idle_cnt <= 32'h0;
        end else begin
            idle_cnt <= idle_cnt + 32'h1;
        end
    end

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    property p_wr_answer;
        s_wr_taken |=> s_wr_answer;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_refuse: assert property (p_refuse) else $error("write taken while busy");
    property p_fifo_cause;
        !$stable(endpoint_fifo_clear) |-> s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_fifo_cause: assert property (p_fifo_cause) else $error("fifo clear moved alone");
    property p_suspend_count;
        $rose(suspend_mode) |-> idle_cnt == SUSPEND_IDLE_CYCLES;
    endproperty
    a_suspend_count: assert property (p_suspend_count) else $error("suspend count wrong");
    property p_suspend_leave;
        bus_activity && suspend_mode |=> !suspend_mode;
    endproperty
    a_suspend_leave: assert property (p_suspend_leave) else $error("suspend kept");
    property p_bus_reset_irq;
        bus_reset_done |-> ##2 irq;
    endproperty
    a_bus_reset_irq: assert property (p_bus_reset_irq) else $error("no irq");
endmodule : udier_props

bind udier_top udier_props #(.SUSPEND_IDLE_CYCLES(SUSPEND_IDLE_CYCLES)) udier_props_i (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .bus_activity, .bus_reset_done,
    .irq, .suspend_mode, .endpoint_fifo_clear
);

//--- sim/udier_tb_top.sv
// Self-checking bench of the interrupt block
`timescale 1ns/1ps
module udier_tb_top
    import udier_pkg::*;
;
    localparam int unsigned SIC = 20;
    typedef struct {
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic [1:0]  rs;
        logic [7:0]  ra;
        logic [31:0] rx;
    } udier_row_t;
    logic              aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic              aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic              s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]        s_axi_wstrb = 4'h0;
    logic [1:0]        s_axi_bresp, s_axi_rresp, r;
    logic              s_axi_rvalid, irq, suspend_mode, bus_activity, resume_seen;
    logic              frame_start_seen, bus_reset_done, bus_reset_seen;
    logic [NUM_EP-1:0] endpoint_fifo_clear;
    logic [NUM_EP-1:0] flg [5] = '{default: '0};
    logic [31:0]       ev [4] = '{32'h0, 32'h800, 32'h2200, 32'h3000};
    int                n_mismatch = 0, num_checks = 0;
    udier_row_t rows [13] = '{
        '{OFF_IRQ_ENABLE, 32'h0, 4'hf, RESP_OKAY, OFF_IRQ_MASK, 32'h1200},
        '{OFF_IRQ_ENABLE, 32'h3f, 4'hf, RESP_OKAY, OFF_IRQ_MASK, 32'h123f},
        '{OFF_IRQ_DISABLE, 32'h5, 4'hf, RESP_OKAY, OFF_IRQ_MASK, 32'h123a},
        '{OFF_IRQ_ENABLE, 32'h2b00, 4'hf, RESP_OKAY, OFF_IRQ_MASK, 32'h3b3a},
        '{OFF_IRQ_DISABLE, 32'h2900, 4'hf, RESP_OKAY, OFF_IRQ_MASK, 32'h123a},
        '{OFF_IRQ_DISABLE, 32'h1000, 4'hf, RESP_OKAY, OFF_IRQ_MASK, 32'h123a},
        '{OFF_IRQ_DISABLE, 32'h0, 4'hf, RESP_OKAY, OFF_IRQ_MASK, 32'h123a},
        '{OFF_IRQ_MASK, 32'hffff_ffff, 4'hf, RESP_OKAY, OFF_IRQ_MASK, 32'h123a},
        '{OFF_ENDPOINT_RESET, 32'hffff_ffff, 4'hf, RESP_OKAY, OFF_ENDPOINT_RESET, 32'h3f},
        '{OFF_ENDPOINT_RESET, 32'h0, 4'he, RESP_OKAY, OFF_ENDPOINT_RESET, 32'h3f},
        '{OFF_ENDPOINT_RESET, 32'h0, 4'hf, RESP_OKAY, OFF_ENDPOINT_RESET, 32'h0},
        '{8'h24, 32'h1, 4'hf, RESP_SLVERR, 8'h24, 32'h0},
        '{OFF_IRQ_ENABLE, 32'h0, 4'hf, RESP_OKAY, OFF_IRQ_DISABLE, 32'h0}
    };

    udier_top #(.SUSPEND_IDLE_CYCLES(SIC)) udier_top_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .setup_received_flag(flg[0]),
        .rx_bank_zero_flag(flg[1]), .rx_bank_one_flag(flg[2]), .tx_complete_flag(flg[3]),
        .stall_acked_flag(flg[4]), .bus_activity, .resume_seen, .frame_start_seen,
        .bus_reset_done, .bus_reset_seen, .irq, .suspend_mode, .endpoint_fifo_clear
    );
    udier_host_model udier_host_model_i (
        .aclk, .bus_activity, .resume_seen, .frame_start_seen, .bus_reset_done,
        .bus_reset_seen
    );

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge aclk);
    endtask : tk
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        logic ap;
        logic wp;
        ap = 1'b1;
        wp = 1'b1;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= v;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        while (ap || wp) begin
            @(posedge aclk);
            if (ap && s_axi_awready === 1'b1) begin
                ap = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (wp && s_axi_wready === 1'b1) begin
                wp = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        // Late ready makes the slave hold its response a cycle
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        // Late ready makes the slave hold its read data a cycle
        @(posedge aclk);
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        chk(d, exp);
    endtask : rdchk
    task automatic report_and_stop();
        if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    initial begin
        tk(20000);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        tk(6);
        aresetn <= 1'b1;
        tk(1);
        wr(OFF_IRQ_CLEAR, 32'h2200, 4'hf);
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd, rows[i].ws);
            chk(32'(r), 32'(rows[i].rs));
            rdchk(rows[i].ra, rows[i].rx);
            chk(32'(r), 32'(rows[i].rs));
        end
        for (int k = 0; k < 5; k++) begin
            flg[k][k] <= 1'b1;
            tk(3);
            rdchk(OFF_IRQ_STATUS, 32'h1 << k);
            chk(32'(irq), (32'h3a >> k) & 32'h1);
            wr(OFF_IRQ_CLEAR, 32'h3f, 4'hf);
            rdchk(OFF_IRQ_STATUS, 32'h1 << k);
            flg[k][k] <= 1'b0;
            tk(3);
            rdchk(OFF_IRQ_STATUS, 32'h0);
        end
        for (int k = 1; k < 4; k++) begin
            udier_host_model_i.send(k);
            tk(3);
            rdchk(OFF_IRQ_STATUS, ev[k]);
            chk(32'(irq), 32'(k != 1));
            wr(OFF_IRQ_CLEAR, ev[k], 4'hf);
            rdchk(OFF_IRQ_STATUS, 32'h0);
            chk(32'(irq), 32'h0);
        end
        udier_host_model_i.set_active(1'b0);
        tk(SIC - 5);
        chk(32'(suspend_mode), 32'h0);
        tk(8);
        chk(32'(suspend_mode), 32'h1);
        rdchk(OFF_IRQ_STATUS, 32'h100);
        chk(32'(irq), 32'h0);
        wr(OFF_IRQ_ENABLE, 32'h100, 4'hf);
        tk(2);
        chk(32'(irq), 32'h1);
        udier_host_model_i.set_active(1'b1);
        tk(2);
        chk(32'(suspend_mode), 32'h0);
        wr(OFF_IRQ_CLEAR, 32'h100, 4'hf);
        tk(2);
        chk(32'(irq), 32'h0);
        wr(OFF_ENDPOINT_RESET, 32'h15, 4'hf);
        tk(2);
        chk(32'(endpoint_fifo_clear), 32'h15);
        wr(OFF_ENDPOINT_RESET, 32'h0, 4'hf);
        tk(2);
        chk(32'(endpoint_fifo_clear), 32'h0);
        wr(OFF_IRQ_ENABLE, 32'h3f, 4'hf);
        wr(OFF_ENDPOINT_RESET, 32'h3f, 4'hf);
        aresetn <= 1'b0;
        tk(2);
        aresetn <= 1'b1;
        tk(1);
        rdchk(OFF_IRQ_MASK, 32'h1200);
        rdchk(OFF_ENDPOINT_RESET, 32'h0);
        report_and_stop();
    end
endmodule : udier_tb_top
